/* common/ccm_pkg.sv */
// Constants for the configurable connection matrix: source codes, sink
// numbers, pin tables, register map and bandgap timing.
// Assumes an APB slave at 100 MHz in front of the selector store.
// Operation
// RQ1: Spare codes low; 62 reset; 63 high
// RQ2: Each sink has own six-bit selector word
// RQ3: Code 18 shared pipe/LUT; 19, 20 taps
// RQ4: Codes 14-17 true/inverted of latches four, five
// RQ5: Codes 22-33 pins; 34-36, 53 oscillators
// RQ6: Delayed bandgap good on 51; detector on 52
// RQ7: Codes 37-40 counters, 41-46 PWM, 47-50 interrupts/comparators
// RQ8: Sinks 8-11 shared two-input cells
// RQ9: Sinks 24-29 shared three-input cells
// RQ10: Sinks 34-39 controls of latches four, five
// RQ11: Sinks 40-42 pipe delay or LUT inputs
// RQ12: Sinks 44-62 pin outputs and enables
// RQ13: Sinks 63, 66, 78 high powers down
// RQ14: Sinks 64, 65 low powers comparators down
// RQ15: Sinks 67-75 counter clock, inputs, keep, up
// RQ16: Sinks 76, 77 PWM register select bits
// RQ17: Sink 43 feeds edge delay; returns code 21
// RQ18: Sixty-four sources, eighty-one sink selectors
// RQ19: Selectors fixed once programmed and locked
// RQ20: Each sink a stateless 64-to-1 multiplexer
package ccm_pkg;
  // Matrix size
  localparam int SRC_COUNT  = 64;
  localparam int SINK_COUNT = 81;
  localparam int SEL_W      = 6;
  localparam int IDX_W      = 7;
  // Source codes
  localparam int CODE_LUT2_BASE  = 1;
  localparam int CODE_LUT3_BASE  = 7;
  localparam int CODE_LUT4       = 13;
  localparam int CODE_LATCH4_Q   = 14;
  localparam int CODE_LATCH4_INV = 15;
  localparam int CODE_LATCH5_Q   = 16;
  localparam int CODE_LATCH5_INV = 17;
  localparam int CODE_PIPE_ONE   = 18;
  localparam int CODE_PIPE_TAP   = 19;
  localparam int CODE_EDGE       = 21;
  localparam int CODE_PIN_BASE   = 22;
  localparam int CODE_RING       = 34;
  localparam int CODE_RC         = 35;
  localparam int CODE_LOW_FREQ   = 36;
  localparam int CODE_CNT_BASE   = 37;
  localparam int CODE_PWM_BASE   = 41;
  localparam int CODE_SER_IRQ    = 47;
  localparam int CODE_ACMP_A     = 48;
  localparam int CODE_ACMP_B     = 49;
  localparam int CODE_CONV_IRQ   = 50;
  localparam int CODE_BANDGAP    = 51;
  localparam int CODE_PWR_DET    = 52;
  localparam int CODE_RC_RAW     = 53;
  localparam int CODE_SPARE_LO   = 54;
  localparam int CODE_SPARE_HI   = 61;
  localparam int CODE_POR        = 62;
  localparam int CODE_VDD        = 63;
  localparam logic [5:0] CODE_GROUND_V = 6'h00;
  localparam logic [5:0] CODE_POR_V    = 6'h3e;
  localparam logic [5:0] CODE_VDD_V    = 6'h3f;
  // Sink numbers
  localparam int SINK_LUT2_SHARE = 8;
  localparam int SINK_LUT3_SHARE = 24;
  localparam int SINK_LATCH4     = 34;
  localparam int SINK_LATCH5     = 37;
  localparam int SINK_PIPE       = 40;
  localparam int SINK_EDGE       = 43;
  localparam int SINK_CONV_PD    = 63;
  localparam int SINK_ACMPA_EN   = 64;
  localparam int SINK_ACMPB_EN   = 65;
  localparam int SINK_OSC_PD     = 66;
  localparam int SINK_CNT_BASE   = 67;
  localparam int SINK_PWM_SEL    = 76;
  localparam int SINK_PWM_PD     = 78;
  localparam int SINK_SER_CS     = 79;
  localparam int SINK_SER_CLK    = 80;
  // Output pins 3,4,5,6,7,9,10,11,12,13,14; zero enable entry means none
  localparam int PIN_COUNT = 11;
  localparam int PIN_OUT_SINK [0:10] = '{44, 46, 48, 50, 51, 53, 55, 56, 57, 59, 61};
  localparam int PIN_OE_SINK  [0:10] = '{45, 47, 49, 0, 52, 54, 0, 0, 58, 60, 62};
  // Register map
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] SEL_BASE_ADDR = 12'h000;
  localparam logic [11:0] SEL_END_ADDR  = 12'h144;
  localparam logic [11:0] CTRL_ADDR     = 12'h200;
  localparam logic [11:0] STATUS_ADDR   = 12'h204;
  localparam int          CTRL_LOCK_BIT = 0;
  localparam int          STAT_BG_BIT   = 0;
  localparam int          STAT_LOCK_BIT = 1;
  localparam logic [5:0]  SEL_RESET     = 6'h00;
  // Bandgap good delay, least time rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int BG_DELAY_NS   = 200;
  localparam int BG_DELAY_CYC  = (BG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BG_CNT_W      = 5;
endpackage : ccm_pkg

/* common/ccm_sel_if.sv */
// Selector store port between the router and its selector bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ccm_sel_if;
  logic                                     wrEn;    // One-cycle write strobe
  logic [ccm_pkg::IDX_W-1:0]                wrIdx;   // Sink written
  logic [ccm_pkg::SEL_W-1:0]                wrData;  // New selector
  logic [ccm_pkg::IDX_W-1:0]                rdIdx;   // Sink read back
  logic [ccm_pkg::SEL_W-1:0]                rdData;  // Registered readback
  logic [ccm_pkg::SEL_W*ccm_pkg::SINK_COUNT-1:0] selFlat; // All selectors
  modport bank (input wrEn, wrIdx, wrData, rdIdx, output rdData, selFlat);
  modport ctrl (output wrEn, wrIdx, wrData, rdIdx, input rdData, selFlat);
endinterface : ccm_sel_if

/* core/ccm_selector_bank.sv */
// Selector store: one six-bit word per sink, parallel view for routing
// and a registered readback port. Assumes writes are already lock-gated.
`timescale 1ns/100ps
module ccm_selector_bank #(
  parameter int DEPTH = ccm_pkg::SINK_COUNT
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  ccm_sel_if.bank    sel
);
  // Depth must fit the index width
  if (DEPTH < 1 || DEPTH > (1 << ccm_pkg::IDX_W)) begin : g_bad_depth
    $error("Selector bank depth out of range");
  end

  logic [ccm_pkg::SEL_W-1:0] word_reg [DEPTH];  // Selector words
  logic [ccm_pkg::SEL_W-1:0] rdData_reg;        // Readback register
  logic                      rdHit;             // Read index in range

  assign rdHit = 32'(sel.rdIdx) < DEPTH;

  // Word store, all grounded after reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++) word_reg[i] <= ccm_pkg::SEL_RESET;
    end
    else if (sel.wrEn && 32'(sel.wrIdx) < DEPTH)
    begin
      word_reg[sel.wrIdx] <= sel.wrData; // RQ2
    end
  end

  // Readback, zero for an index past the end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData_reg <= '0;
    else
      rdData_reg <= rdHit ? word_reg[sel.rdIdx] : '0;
  end

  assign sel.rdData = rdData_reg;

  // Parallel view, word k at bits 6k+5..6k
  for (genvar k = 0; k < DEPTH; k++) begin : g_flat
    assign sel.selFlat[k*ccm_pkg::SEL_W +: ccm_pkg::SEL_W] = word_reg[k]; // RQ2
  end

  AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ2
    sel.wrEn |=> sel.selFlat[$past(sel.wrIdx)*ccm_pkg::SEL_W +: ccm_pkg::SEL_W]
                 == $past(sel.wrData))
    else $error("Selector word did not take the written value");
endmodule : ccm_selector_bank

/* core/ccm_router.sv */
// Connection matrix: 64 hard-wired sources, 81 selector-driven sinks,
// selectors loaded and locked over APB. Routing is combinational.
// Assumes sources and sink users are the device's own cells.
`timescale 1ns/100ps
module ccm_router (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sources
  input  wire logic [5:0]  lutTwoOut,
  input  wire logic [5:0]  lutThreeOut,
  input  wire logic        patternOut,
  input  wire logic        latchFourQ,
  input  wire logic        latchFourInvertedOutput,
  input  wire logic        latchFiveQ,
  input  wire logic        latchFiveInvertedOutput,
  input  wire logic        pipeSingleOut,
  input  wire logic [1:0]  pipeTapOut,
  input  wire logic        edgeDelayOut,
  input  wire logic [11:0] pinIn,
  input  wire logic        ringOscOut,
  input  wire logic        rcOscOut,
  input  wire logic        lowFreqOscOut,
  input  wire logic [3:0]  counterDelayOut,
  input  wire logic [5:0]  pwmCompOut,
  input  wire logic        serialIrq,
  input  wire logic        analogComparatorA,
  input  wire logic        analogComparatorB,
  input  wire logic        converterIrq,
  input  wire logic        bandgapGood,
  input  wire logic        powerDetect,
  input  wire logic        rcOscRaw,
  input  wire logic        powerOnReset_n,
  // Sinks
  output logic [80:0]      sinkOut,
  output logic [3:0]       lutTwoShareIn,
  output logic [5:0]       lutThreeShareIn,
  output logic [2:0]       latchFourCtl,
  output logic [2:0]       latchFiveCtl,
  output logic [2:0]       pipeCtl,
  output logic             edgeDelayIn,
  output logic [10:0]      pinOut,
  output logic [10:0]      pinOe,
  output logic             converterPowerDown,
  output logic             comparatorAPowerEnable_n,
  output logic             comparatorBPowerEnable_n,
  output logic             oscPowerDown,
  output logic [8:0]       counterCtl,
  output logic [1:0]       pwmRegSel,
  output logic             pwmPowerDown,
  output logic             serialSelect_n,
  output logic             serialClock
);
  ccm_sel_if selBus ();  // Selector store port

  // Source vector, index equals source code
  logic [ccm_pkg::SRC_COUNT-1:0] srcVec;

  // Bandgap good synchroniser and delay
  logic                        bgMeta_reg;         // First stage only
  logic                        bgSync_reg;         // Usable level
  logic [ccm_pkg::BG_CNT_W-1:0] bgCnt_reg;          // Stable-high count
  logic                        bandgapDelayed_reg; // Delayed indication
  localparam logic [ccm_pkg::BG_CNT_W-1:0] BG_LAST =
    ccm_pkg::BG_CNT_W'(ccm_pkg::BG_DELAY_CYC - 1);

  // APB state
  logic [31:0] prdata_reg;   // Read data
  logic        pready_reg;   // Access done
  logic        pslverr_reg;  // Error answer
  logic        lock_reg;     // Selectors frozen

  // Decode
  logic        accessPh;     // Access phase
  logic        doneEdge;     // Transfer completes at this edge
  logic        isSel;        // Selector word hit
  logic        isCtrl;       // Control register hit
  logic        isStat;       // Status register hit
  logic        mapped;       // Any register hit
  logic        errNow;       // Transfer will be refused
  logic [31:0] readMux;      // Read data for this address

  // Hard-wired sources
  assign srcVec[0]                              = 1'b0; // RQ1
  assign srcVec[ccm_pkg::CODE_LUT2_BASE +: 6]   = lutTwoOut; // RQ18
  assign srcVec[ccm_pkg::CODE_LUT3_BASE +: 6]   = lutThreeOut; // RQ18
  assign srcVec[ccm_pkg::CODE_LUT4]             = patternOut; // RQ18
  assign srcVec[ccm_pkg::CODE_LATCH4_Q]         = latchFourQ; // RQ4
  assign srcVec[ccm_pkg::CODE_LATCH4_INV]       = latchFourInvertedOutput; // RQ4
  assign srcVec[ccm_pkg::CODE_LATCH5_Q]         = latchFiveQ; // RQ4
  assign srcVec[ccm_pkg::CODE_LATCH5_INV]       = latchFiveInvertedOutput; // RQ4
  assign srcVec[ccm_pkg::CODE_PIPE_ONE]         = pipeSingleOut; // RQ3
  assign srcVec[ccm_pkg::CODE_PIPE_TAP +: 2]    = pipeTapOut; // RQ3
  assign srcVec[ccm_pkg::CODE_EDGE]             = edgeDelayOut; // RQ17
  assign srcVec[ccm_pkg::CODE_PIN_BASE +: 12]   = pinIn; // RQ5
  assign srcVec[ccm_pkg::CODE_RING]             = ringOscOut; // RQ5
  assign srcVec[ccm_pkg::CODE_RC]               = rcOscOut; // RQ5
  assign srcVec[ccm_pkg::CODE_LOW_FREQ]         = lowFreqOscOut; // RQ5
  assign srcVec[ccm_pkg::CODE_CNT_BASE +: 4]    = counterDelayOut; // RQ7
  assign srcVec[ccm_pkg::CODE_PWM_BASE +: 6]    = pwmCompOut; // RQ7
  assign srcVec[ccm_pkg::CODE_SER_IRQ]          = serialIrq; // RQ7
  assign srcVec[ccm_pkg::CODE_ACMP_A]           = analogComparatorA; // RQ7
  assign srcVec[ccm_pkg::CODE_ACMP_B]           = analogComparatorB; // RQ7
  assign srcVec[ccm_pkg::CODE_CONV_IRQ]         = converterIrq; // RQ7
  assign srcVec[ccm_pkg::CODE_BANDGAP]          = bandgapDelayed_reg; // RQ6
  assign srcVec[ccm_pkg::CODE_PWR_DET]          = powerDetect; // RQ6
  assign srcVec[ccm_pkg::CODE_RC_RAW]           = rcOscRaw; // RQ5
  assign srcVec[ccm_pkg::CODE_SPARE_LO +: 8]    = 8'h00; // RQ1
  assign srcVec[ccm_pkg::CODE_POR]              = powerOnReset_n; // RQ1
  assign srcVec[ccm_pkg::CODE_VDD]              = 1'b1; // RQ1

  // One stateless 64-to-1 selector per sink
  for (genvar k = 0; k < ccm_pkg::SINK_COUNT; k++) begin : g_sink
    assign sinkOut[k] = srcVec[selBus.selFlat[k*ccm_pkg::SEL_W +: ccm_pkg::SEL_W]]; // RQ20
  end

  // Named sink groups
  assign lutTwoShareIn   = sinkOut[ccm_pkg::SINK_LUT2_SHARE +: 4]; // RQ8
  assign lutThreeShareIn = sinkOut[ccm_pkg::SINK_LUT3_SHARE +: 6]; // RQ9
  assign latchFourCtl    = sinkOut[ccm_pkg::SINK_LATCH4 +: 3]; // RQ10
  assign latchFiveCtl    = sinkOut[ccm_pkg::SINK_LATCH5 +: 3]; // RQ10
  assign pipeCtl         = sinkOut[ccm_pkg::SINK_PIPE +: 3]; // RQ11
  assign edgeDelayIn     = sinkOut[ccm_pkg::SINK_EDGE]; // RQ17
  assign converterPowerDown       = sinkOut[ccm_pkg::SINK_CONV_PD]; // RQ13
  assign oscPowerDown             = sinkOut[ccm_pkg::SINK_OSC_PD]; // RQ13
  assign pwmPowerDown             = sinkOut[ccm_pkg::SINK_PWM_PD]; // RQ13
  assign comparatorAPowerEnable_n = sinkOut[ccm_pkg::SINK_ACMPA_EN]; // RQ14
  assign comparatorBPowerEnable_n = sinkOut[ccm_pkg::SINK_ACMPB_EN]; // RQ14
  assign counterCtl      = sinkOut[ccm_pkg::SINK_CNT_BASE +: 9]; // RQ15
  assign pwmRegSel       = sinkOut[ccm_pkg::SINK_PWM_SEL +: 2]; // RQ16
  assign serialSelect_n  = sinkOut[ccm_pkg::SINK_SER_CS]; // RQ2
  assign serialClock     = sinkOut[ccm_pkg::SINK_SER_CLK]; // RQ2

  // Pin outputs and enables; pins without a matrix enable show low
  for (genvar p = 0; p < ccm_pkg::PIN_COUNT; p++) begin : g_pin
    assign pinOut[p] = sinkOut[ccm_pkg::PIN_OUT_SINK[p]]; // RQ12
    if (ccm_pkg::PIN_OE_SINK[p] != 0) begin : g_oe
      assign pinOe[p] = sinkOut[ccm_pkg::PIN_OE_SINK[p]]; // RQ12
    end
    else begin : g_no_oe
      assign pinOe[p] = 1'b0;
    end
  end

  // Bandgap level through two flops
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bgMeta_reg <= 1'b0;
      bgSync_reg <= 1'b0;
    end
    else
    begin
      bgMeta_reg <= bandgapGood;
      bgSync_reg <= bgMeta_reg;
    end
  end

  // Rise delayed by the bandgap time, fall passes at once
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bgCnt_reg          <= '0;
      bandgapDelayed_reg <= 1'b0;
    end
    else if (!bgSync_reg)
    begin
      bgCnt_reg          <= '0;
      bandgapDelayed_reg <= 1'b0;
    end
    else if (bgCnt_reg != BG_LAST)
      bgCnt_reg <= bgCnt_reg + 1'b1; // RQ6
    else
      bandgapDelayed_reg <= 1'b1; // RQ6
  end

  // Address decode
  assign accessPh = psel & penable;
  assign doneEdge = accessPh & pready_reg;
  assign isSel    = (paddr[1:0] == 2'b00) && (paddr < ccm_pkg::SEL_END_ADDR);
  assign isCtrl   = paddr == ccm_pkg::CTRL_ADDR;
  assign isStat   = paddr == ccm_pkg::STATUS_ADDR;
  assign mapped   = isSel | isCtrl | isStat;
  assign errNow   = ~mapped | (pwrite & isSel & lock_reg); // RQ19

  // Read data selection
  assign readMux  = isSel  ? {26'h0000000, selBus.rdData} :
                    isCtrl ? {31'h00000000, lock_reg} :
                    isStat ? {30'h00000000, lock_reg, bandgapDelayed_reg} :
                             32'h00000000;

  // Bank port: index from the word address, writes only when unlocked
  assign selBus.rdIdx  = paddr[8:2];
  assign selBus.wrIdx  = paddr[8:2];
  assign selBus.wrData = pwdata[5:0];
  assign selBus.wrEn   = doneEdge & pwrite & isSel & ~lock_reg; // RQ19

  // Answer one cycle into the access phase
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else if (accessPh && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= errNow;
      prdata_reg  <= pwrite ? 32'h00000000 : readMux;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Lock is sticky until reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lock_reg <= 1'b0;
    else if (doneEdge && pwrite && isCtrl && pwdata[ccm_pkg::CTRL_LOCK_BIT])
      lock_reg <= 1'b1; // RQ19
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Selector store
  ccm_selector_bank #(
    .DEPTH (ccm_pkg::SINK_COUNT)
  ) u_ccm_selector_bank (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .sel     (selBus)
  );

  // Checks
  logic [5:0] selLast;   // Selector of the serial clock sink
  logic [5:0] selPin3;   // Selector of pin 3 output
  logic [5:0] selPwmLo;  // Selector of PWM select bit 0
  logic [5:0] selPwmHi;  // Selector of PWM select bit 1
  assign selLast  = selBus.selFlat[ccm_pkg::SINK_SER_CLK*6 +: 6];
  assign selPwmLo = selBus.selFlat[ccm_pkg::SINK_PWM_SEL*6 +: 6];
  assign selPwmHi = selBus.selFlat[(ccm_pkg::SINK_PWM_SEL+1)*6 +: 6];
  assign selPin3 = selBus.selFlat[ccm_pkg::PIN_OUT_SINK[0]*6 +: 6];

  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence apbWait;
    psel && penable && !pready;
  endsequence

  AST_GROUND_CODES: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ1
    (selLast == ccm_pkg::CODE_GROUND_V || (selLast >= 6'h36 && selLast <= 6'h3d))
      |-> !sinkOut[ccm_pkg::SINK_SER_CLK])
    else $error("Ground code did not give low");
  AST_TIE_CODES: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ1
    (selLast == ccm_pkg::CODE_VDD_V |-> sinkOut[ccm_pkg::SINK_SER_CLK]) and
    (selLast == ccm_pkg::CODE_POR_V |-> sinkOut[ccm_pkg::SINK_SER_CLK] == powerOnReset_n))
    else $error("High or reset code routed wrongly");
  AST_INV_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ4
    selLast == 6'h0f |-> sinkOut[ccm_pkg::SINK_SER_CLK] == latchFourInvertedOutput)
    else $error("Inverted latch output not routed");
  AST_PIN_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    selPin3 == 6'h16 |-> pinOut[0] == pinIn[0])
    else $error("Pin output did not follow pin input code");
  AST_BG_DELAY: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ6
    $rose(bandgapDelayed_reg) |-> $past(bgCnt_reg) == BG_LAST && $past(bgSync_reg))
    else $error("Bandgap indication rose too early");
  AST_BG_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ6
    $rose(bgSync_reg) |-> !bandgapDelayed_reg [*8])
    else $error("Bandgap indication not delayed");
  AST_LOCK_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ19
    (apbWait and (pwrite && isSel && lock_reg)) |=> pready && pslverr)
    else $error("Locked selector write not refused");
  AST_APB_TIMING: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ2
    apbSetup ##1 apbWait |=> pready)
    else $error("Answer not one cycle into access");
  AST_POWER_SINKS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    selBus.selFlat[ccm_pkg::SINK_CONV_PD*6 +: 6] == ccm_pkg::CODE_VDD_V
      |-> converterPowerDown)
    else $error("Converter power-down not routed");
  AST_PWM_SEL: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ16
    selPwmHi == ccm_pkg::CODE_VDD_V && selPwmLo == ccm_pkg::CODE_GROUND_V
      |-> pwmRegSel == 2'b10)
    else $error("PWM select bits misordered");
endmodule : ccm_router

/* bench/ccm_src_model.sv */
// Far-side source cells: drives the 64 matrix source lines.
// Assumes the bench sets each cell's level through one pattern word.
`timescale 1ns/100ps
module ccm_src_model (
  input  wire logic [63:0] pattern,  // Wanted level per source code
  output logic      [63:0] srcBus    // Levels seen by the router
);
  // Cells settle at once; the router alone decides grounds and supply
  assign srcBus = pattern;
endmodule : ccm_src_model

/* bench/tb_top.sv */
// Bench for the connection matrix: selectors loaded over APB, sources toggled.
// Assumes one APB wait state and combinational routing behind it.
`timescale 1ns/100ps
module tb_top;
  localparam logic [63:0] BG_MASK = 64'hfff7_ffff_ffff_ffff; // Bandgap line kept low
  logic        ref_clk = 1'b0;        // 100 MHz clock
  logic        rst_b   = 1'b0;        // Reset, active low
  logic        psel    = 1'b0;        // APB request
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;                // APB answer
  logic        pready;
  logic        pslverr;
  logic [63:0] pattern = 64'h0;       // Source levels wanted
  logic [63:0] src;                   // Source lines
  logic [80:0] sinkOut;               // All sinks
  wire  [59:0] grp;                   // Named sink groups, packed
  logic [31:0] rd;                    // Last read data
  logic        err;                   // Last error flag
  int          n_errors = 0;          // Mismatches
  int          n_checks = 0;          // Comparisons
  int          cycles   = 0;          // Timeout counter
  // Clock
  always #5 ref_clk = ~ref_clk;
  ccm_src_model u_ccm_src_model (.pattern(pattern), .srcBus(src));
  ccm_router u_ccm_router (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lutTwoOut(src[6:1]), .lutThreeOut(src[12:7]), .patternOut(src[13]),
    .latchFourQ(src[14]), .latchFourInvertedOutput(src[15]), .latchFiveQ(src[16]),
    .latchFiveInvertedOutput(src[17]), .pipeSingleOut(src[18]), .pipeTapOut(src[20:19]),
    .edgeDelayOut(src[21]), .pinIn(src[33:22]), .ringOscOut(src[34]), .rcOscOut(src[35]),
    .lowFreqOscOut(src[36]), .counterDelayOut(src[40:37]), .pwmCompOut(src[46:41]),
    .serialIrq(src[47]), .analogComparatorA(src[48]), .analogComparatorB(src[49]),
    .converterIrq(src[50]), .bandgapGood(src[51]), .powerDetect(src[52]),
    .rcOscRaw(src[53]), .powerOnReset_n(src[62]), .sinkOut(sinkOut),
    .lutTwoShareIn(grp[3:0]), .lutThreeShareIn(grp[9:4]), .latchFourCtl(grp[12:10]),
    .latchFiveCtl(grp[15:13]), .pipeCtl(grp[18:16]), .edgeDelayIn(grp[19]),
    .pinOut(grp[30:20]), .pinOe(grp[41:31]), .converterPowerDown(grp[42]),
    .comparatorAPowerEnable_n(grp[43]), .comparatorBPowerEnable_n(grp[44]),
    .oscPowerDown(grp[45]), .counterCtl(grp[54:46]), .pwmRegSel(grp[56:55]),
    .pwmPowerDown(grp[57]), .serialSelect_n(grp[58]), .serialClock(grp[59]));
  // Level a source code should put on its sinks
  function automatic logic expSrc(input int code, input logic [63:0] pat);
    if (code == 0 || (code >= ccm_pkg::CODE_SPARE_LO && code <= ccm_pkg::CODE_SPARE_HI))
      return 1'b0;
    if (code == ccm_pkg::CODE_VDD)
      return 1'b1;
    return pat[code];
  endfunction : expSrc
  // Named groups expected from a sink vector
  function automatic logic [59:0] grpOf(input logic [80:0] s);
    logic [10:0] po;
    logic [10:0] pe;
    for (int i = 0; i < ccm_pkg::PIN_COUNT; i++)
    begin
      po[i] = s[ccm_pkg::PIN_OUT_SINK[i]];
      pe[i] = (ccm_pkg::PIN_OE_SINK[i] == 0) ? 1'b0 : s[ccm_pkg::PIN_OE_SINK[i]];
    end
    return {s[80:76], s[75:67], s[66:63], pe, po, s[43:34], s[29:24], s[11:8]};
  endfunction : grpOf
  // Compare and count
  task automatic chk(input string name, input logic [80:0] exp, input logic [80:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w == 50)
      chk("apbReady", 81'(1), 81'(0));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reset state of sinks and registers
  task automatic testReset();
    chk("sinkOut", 81'(0), sinkOut);
    chk("groups", 81'(0), 81'(grp));
    apb(1'b0, 12'h140, 32'h0);
    chk("sel80", 81'(0), 81'({err, rd}));
    $display("test reset done");
  endtask : testReset
  // Every source code on sink 80, two patterns opposite except the bandgap line, low in both
  task automatic testCodes();
    logic [63:0] pa;
    pa = 64'ha5c3_9612_f0e1_7b4d & BG_MASK;
    for (int c = 0; c < 64; c++)
    begin
      apb(1'b1, 12'h140, 32'(c));
      for (int j = 0; j < 2; j++)
      begin
        pattern <= (j == 1) ? (~pa & BG_MASK) : pa;
        @(negedge ref_clk);
        chk("sink80", 81'(expSrc(c, pattern)), 81'(sinkOut[80]));
        chk("serialClock", 81'(expSrc(c, pattern)), 81'(grp[59]));
        @(posedge ref_clk);
      end
    end
    apb(1'b1, 12'h140, 32'h0);
    $display("test codes done");
  endtask : testCodes
  // Each sink alone tied high, others grounded with all sources but the bandgap line high
  task automatic testSinks();
    logic [80:0] e;
    pattern <= BG_MASK;
    for (int k = 0; k < 81; k++)
    begin
      e = 81'(1) << k;
      apb(1'b1, 12'(4 * k), 32'(ccm_pkg::CODE_VDD));
      @(negedge ref_clk);
      chk("sinkOne", e, sinkOut);
      chk("groupOne", 81'(grpOf(e)), 81'(grp));
      apb(1'b1, 12'(4 * k), 32'h0);
    end
    apb(1'b1, 12'h0b0, 32'(ccm_pkg::CODE_PIN_BASE));
    @(negedge ref_clk);
    chk("pinLoop", 81'(1), 81'(grp[20]));
    apb(1'b1, 12'h0b0, 32'h0);
    $display("test sinks done");
  endtask : testSinks
  // Bandgap indication is held back before it reaches code 51
  task automatic testBandgap();
    int w;
    w = 0;
    apb(1'b1, 12'h140, 32'(ccm_pkg::CODE_BANDGAP));
    pattern <= ~BG_MASK;
    repeat (19) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("bandgapEarly", 81'(0), 81'(sinkOut[80]));
    while (sinkOut[80] !== 1'b1 && w < 30)
    begin
      @(negedge ref_clk);
      w++;
    end
    chk("bandgapLate", 81'(1), 81'(sinkOut[80]));
    apb(1'b0, ccm_pkg::STATUS_ADDR, 32'h0);
    chk("statusBg", 81'(1), 81'(rd));
    pattern <= 64'h0;
    repeat (6) @(negedge ref_clk);
    chk("bandgapFall", 81'(0), 81'(sinkOut[80]));
    $display("test bandgap done");
  endtask : testBandgap
  // Readback, unmapped places and locking
  task automatic testLock();
    apb(1'b1, 12'h014, 32'hffff_ffea);
    apb(1'b0, 12'h014, 32'h0);
    chk("selRead", 81'(33'h02a), 81'({err, rd}));
    apb(1'b0, 12'h144, 32'h0);
    chk("unmappedRd", 81'(33'h1_0000_0000), 81'({err, rd}));
    apb(1'b1, 12'h300, 32'h1);
    chk("unmappedWr", 81'(1), 81'(err));
    apb(1'b1, ccm_pkg::CTRL_ADDR, 32'h1);
    chk("lockWr", 81'(0), 81'(err));
    apb(1'b0, ccm_pkg::STATUS_ADDR, 32'h0);
    chk("statusLock", 81'(2), 81'(rd));
    apb(1'b1, 12'h014, 32'h3);
    chk("lockedWr", 81'(1), 81'(err));
    apb(1'b0, 12'h014, 32'h0);
    chk("lockedRead", 81'(33'h02a), 81'({err, rd}));
    $display("test lock done");
  endtask : testLock
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    testReset();
    testCodes();
    testSinks();
    testBandgap();
    testLock();
    end_of_test();
  end
endmodule : tb_top
